// *** hdl/pmbid_pkg.sv ***
// Purpose: Shared constants and types for the identification and warning response bank.
// Assumes: Byte 0 of every string sits in bits 7:0 of its vector.
// Notes:   Store bases index the shared byte store of writable strings.
package pmbid_pkg;

    localparam logic [7:0] CMD_PROTO_REV  = 8'h98;
    localparam logic [7:0] CMD_MAKER_ID   = 8'h99;
    localparam logic [7:0] CMD_MODEL      = 8'h9a;
    localparam logic [7:0] CMD_PROD_REV   = 8'h9b;
    localparam logic [7:0] CMD_LOCATION   = 8'h9c;
    localparam logic [7:0] CMD_DATE       = 8'h9d;
    localparam logic [7:0] CMD_SERIAL     = 8'h9e;
    localparam logic [7:0] CMD_CTRL_ID    = 8'had;
    localparam logic [7:0] CMD_CTRL_REV   = 8'hae;
    localparam logic [7:0] CMD_USER_AREA  = 8'hb0;
    localparam logic [7:0] CMD_WARN_ACT   = 8'hc4;

    localparam logic [4:0] LEN_SHORT_STR  = 5'h0c;
    localparam logic [4:0] LEN_LONG_STR   = 5'h14;
    localparam logic [4:0] LEN_CTRL_STR   = 5'h08;
    localparam logic [4:0] LEN_USER_AREA  = 5'h10;
    localparam logic [4:0] LEN_ONE_BYTE   = 5'h01;

    localparam logic [6:0] BASE_MAKER_ID  = 7'h00;
    localparam logic [6:0] BASE_MODEL     = 7'h0c;
    localparam logic [6:0] BASE_PROD_REV  = 7'h20;
    localparam logic [6:0] BASE_LOCATION  = 7'h2c;
    localparam logic [6:0] BASE_USER_AREA = 7'h38;
    localparam int         STORE_BYTES    = 72;

    localparam int         ACT_RESP_HI    = 7;
    localparam int         ACT_RESP_LO    = 6;
    localparam int         ACT_RETRY_HI   = 5;
    localparam int         ACT_RETRY_LO   = 3;
    localparam int         ACT_DELAY_HI   = 2;
    localparam int         ACT_DELAY_LO   = 0;
    localparam logic [7:0] ACT_RESET      = 8'h00;

    localparam logic [1:0] RESP_IGNORE    = 2'h0;
    localparam logic [1:0] RESP_DELAYED   = 2'h1;
    localparam logic [1:0] RESP_DISABLE   = 2'h2;
    localparam logic [1:0] RESP_LATCH     = 2'h3;
    localparam logic [2:0] RETRY_NONE     = 3'h0;
    localparam logic [2:0] RETRY_FOREVER  = 3'h7;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_STORE, SRC_PROTO, SRC_DATE, SRC_SERIAL, SRC_CID, SRC_CREV, SRC_ACT
    } pmbid_src_e;

    typedef struct packed {
        logic       hit;
        logic       wr;
        logic [6:0] base;
        logic [4:0] len;
        pmbid_src_e src;
    } pmbid_cmd_s;

    // Delay code n stands for 2**n units, so 0..7 gives 1..128.
    function automatic logic [7:0] pmbid_units(input logic [2:0] code);
        pmbid_units = 8'(9'h001 << code);
    endfunction

endpackage

// *** hdl/pmbid_delay_timer.sv ***
// Purpose: Counts a delay of 1 to 128 delay units.
// Assumes: unit_tick pulses once per delay unit, one clock wide.
// Notes:   A load while busy restarts the count.
`timescale 1ns/10ps
module pmbid_delay_timer import pmbid_pkg::*; (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       load,
    input  wire logic [2:0] code,
    input  wire logic       unit_tick,
    output logic            done_r
);
    logic [7:0] left_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left_r <= 8'h00;
            done_r <= 1'b0;
        end else if (load) begin
            left_r <= pmbid_units(code);
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (unit_tick && left_r != 8'h00) begin
                left_r <= left_r - 8'h01;
                done_r <= (left_r == 8'h01);
            end
        end
    end
endmodule // pmbid_delay_timer

// *** hdl/pmbid_byte_store.sv ***
// Purpose: Flip-flop byte store for the writable strings and user area.
// Assumes: Addresses are checked against the store size by the caller.
// Notes:   Read is combinational so the bank can register it once.
`timescale 1ns/10ps
module pmbid_byte_store import pmbid_pkg::*; (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] rd_data
);
    logic [7:0] mem_r [STORE_BYTES];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < STORE_BYTES; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_addr];
endmodule // pmbid_byte_store

// *** hdl/pmbid_bank.sv ***
// Purpose: Identification command bank and input over-voltage warning response.
// Assumes: One command byte per cmd_valid pulse; answer follows one clock later.
// Notes:   Delay unit ticks, fault clears and the warning come from outside.
// Function
// - Revision byte upper nibble gives first-part revision, codes 0 to 3.
// - Revision byte lower nibble gives second-part revision, codes 0 to 3.
// - Writable maker identity string, up to 12 ASCII characters, readable.
// - Writable model string, up to 20 ASCII characters, readable.
// - Writable product revision string, 96 bits, 12 characters.
// - Writable build location string, up to 12 characters, readable.
// - Date read returns a build date string of at most 12 characters.
// - Serial read returns a 13-character identity in a 20-character field.
// - Sixteen-byte user area that the host can store and read back.
// - Response 00 keeps the output running through the warning.
// - Response 01 runs for the delay, then disables and follows retry field if warning persists.
// - Response 10 disables the output at once, then follows retry field.
// - Response 11 keeps output off until clear, reset or off-then-on.
// - Retry codes 001 and 010 give one or two attempts, then latch off.
// - Attempts start two programmed delay intervals apart.
// - Codes 011 to 110 give three to six attempts; 111 retries forever.
// - Delay code 0 to 7 means 1 to 128 delay units.
`timescale 1ns/10ps
module pmbid_bank import pmbid_pkg::*; #(
    parameter logic [7:0]   PROTO_REV_BYTE = 8'h32,
    parameter logic [95:0]  DATE_STR       = {12{8'h30}},
    parameter logic [159:0] SERIAL_STR     = {{7{8'h20}}, {13{8'h41}}},
    // Arbitrary neutral identity values.
    parameter logic [63:0]  CTRL_ID_STR    = {8{8'h58}},
    parameter logic [63:0]  CTRL_REV_STR   = {8{8'h30}}
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_write,
    input  wire logic [7:0] cmd_code,
    input  wire logic [4:0] cmd_idx,
    input  wire logic [7:0] cmd_wdata,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    output logic      [4:0] rsp_len,
    output logic            rsp_nack,
    input  wire logic       warn_in,
    input  wire logic       unit_tick,
    input  wire logic       fault_clear,
    input  wire logic       run_cmd,
    output logic            out_enable,
    output logic            fault_latched,
    output logic      [2:0] retries_left,
    output logic      [7:0] warn_action
);

    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_OFFW  = 5'b00100,
        ST_TRY   = 5'b01000,
        ST_LATCH = 5'b10000
    } pmbid_state_e;

    function automatic pmbid_cmd_s cmd_decode(input logic [7:0] code);
        pmbid_cmd_s m;
        m = '{hit: 1'b1, wr: 1'b0, base: 7'h00, len: LEN_SHORT_STR, src: SRC_NONE};
        if (code == CMD_PROTO_REV) begin
            m.len = LEN_ONE_BYTE;
            m.src = SRC_PROTO;
        end else if (code == CMD_MAKER_ID) begin
            m.wr   = 1'b1;
            m.base = BASE_MAKER_ID;
            m.src  = SRC_STORE;
        end else if (code == CMD_MODEL) begin
            m.wr   = 1'b1;
            m.base = BASE_MODEL;
            m.len  = LEN_LONG_STR;
            m.src  = SRC_STORE;
        end else if (code == CMD_PROD_REV) begin
            m.wr   = 1'b1;
            m.base = BASE_PROD_REV;
            m.src  = SRC_STORE;
        end else if (code == CMD_LOCATION) begin
            m.wr   = 1'b1;
            m.base = BASE_LOCATION;
            m.src  = SRC_STORE;
        end else if (code == CMD_DATE) begin
            m.src = SRC_DATE;
        end else if (code == CMD_SERIAL) begin
            m.len = LEN_LONG_STR;
            m.src = SRC_SERIAL;
        end else if (code == CMD_CTRL_ID) begin
            m.len = LEN_CTRL_STR;
            m.src = SRC_CID;
        end else if (code == CMD_CTRL_REV) begin
            m.len = LEN_CTRL_STR;
            m.src = SRC_CREV;
        end else if (code == CMD_USER_AREA) begin
            m.wr   = 1'b1;
            m.base = BASE_USER_AREA;
            m.len  = LEN_USER_AREA;
            m.src  = SRC_STORE;
        end else if (code == CMD_WARN_ACT) begin
            m.wr  = 1'b1;
            m.len = LEN_ONE_BYTE;
            m.src = SRC_ACT;
        end else begin
            m.hit = 1'b0;
            m.len = 5'h00;
        end
        return m;
    endfunction

    pmbid_cmd_s   dec;
    logic         idx_ok;
    logic         acc_ok;
    logic         st_wr;
    logic [6:0]   st_addr;
    logic [7:0]   st_rd;
    logic [7:0]   rd_byte;
    logic [7:0]   action_r;
    pmbid_state_e state_r;
    pmbid_state_e state_nxt;
    logic [2:0]   left_r;
    logic [2:0]   left_nxt;
    logic         tmr_load;
    logic         tmr_done;
    logic [1:0]   resp;
    logic [2:0]   retry;

    assign dec     = cmd_decode(cmd_code);
    assign idx_ok  = cmd_idx < dec.len;
    assign acc_ok  = dec.hit && idx_ok && (!cmd_write || dec.wr);
    assign st_addr = dec.base + 7'(cmd_idx);
    assign st_wr   = cmd_valid && cmd_write && acc_ok && dec.src == SRC_STORE;
    assign resp    = action_r[ACT_RESP_HI:ACT_RESP_LO];
    assign retry   = action_r[ACT_RETRY_HI:ACT_RETRY_LO];

    pmbid_byte_store u_store (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (st_wr),
        .wr_addr (st_addr),
        .wr_data (cmd_wdata),
        .rd_addr (st_addr),
        .rd_data (st_rd)
    );

    pmbid_delay_timer u_timer (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .load      (tmr_load),
        .code      (action_r[ACT_DELAY_HI:ACT_DELAY_LO]),
        .unit_tick (unit_tick),
        .done_r    (tmr_done)
    );

    always_comb begin
        rd_byte = 8'h00;
        case (dec.src)
            SRC_STORE:  rd_byte = st_rd;
            SRC_PROTO:  rd_byte = PROTO_REV_BYTE;
            SRC_DATE:   rd_byte = DATE_STR[cmd_idx * 8 +: 8];
            SRC_SERIAL: rd_byte = SERIAL_STR[cmd_idx * 8 +: 8];
            SRC_CID:    rd_byte = CTRL_ID_STR[cmd_idx[2:0] * 8 +: 8];
            SRC_CREV:   rd_byte = CTRL_REV_STR[cmd_idx[2:0] * 8 +: 8];
            SRC_ACT:    rd_byte = action_r;
            default:    rd_byte = 8'h00;
        endcase
    end

    // Refused accesses answer with nack and zero data so stale bytes never leak.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_len   <= 5'h00;
            rsp_nack  <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
            rsp_nack  <= cmd_valid && !acc_ok;
            rsp_len   <= cmd_valid ? dec.len : 5'h00;
            rsp_data  <= (cmd_valid && !cmd_write && acc_ok) ? rd_byte : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            action_r <= ACT_RESET;
        end else if (cmd_valid && cmd_write && acc_ok && dec.src == SRC_ACT) begin
            action_r <= cmd_wdata;
        end
    end

    // A commanded off always drops to run, which also clears a latched fault.
    always_comb begin
        state_nxt = state_r;
        left_nxt  = left_r;
        tmr_load  = 1'b0;
        if (!run_cmd) begin
            state_nxt = ST_RUN;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (warn_in && resp == RESP_DELAYED) begin
                        state_nxt = ST_DELAY;
                        tmr_load  = 1'b1;
                    end else if (warn_in && resp == RESP_DISABLE) begin
                        state_nxt = (retry == RETRY_NONE) ? ST_LATCH : ST_OFFW;
                        left_nxt  = retry;
                        tmr_load  = 1'b1;
                    end else if (warn_in && resp == RESP_LATCH) begin
                        state_nxt = ST_LATCH;
                    end
                end
                ST_DELAY: begin
                    if (!warn_in) begin
                        state_nxt = ST_RUN;
                    end else if (tmr_done) begin
                        state_nxt = (retry == RETRY_NONE) ? ST_LATCH : ST_OFFW;
                        left_nxt  = retry;
                        tmr_load  = 1'b1;
                    end
                end
                ST_OFFW: begin
                    if (tmr_done) begin
                        state_nxt = ST_TRY;
                        tmr_load  = 1'b1;
                    end
                end
                ST_TRY: begin
                    if (tmr_done && !warn_in) begin
                        state_nxt = ST_RUN;
                    end else if (tmr_done && left_r == RETRY_FOREVER) begin
                        state_nxt = ST_OFFW;
                        tmr_load  = 1'b1;
                    end else if (tmr_done && left_r == 3'h1) begin
                        state_nxt = ST_LATCH;
                        left_nxt  = 3'h0;
                    end else if (tmr_done) begin
                        state_nxt = ST_OFFW;
                        left_nxt  = left_r - 3'h1;
                        tmr_load  = 1'b1;
                    end
                end
                ST_LATCH: begin
                    if (fault_clear) begin
                        state_nxt = ST_RUN;
                    end
                end
                default: state_nxt = ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_RUN;
            left_r  <= 3'h0;
        end else begin
            state_r <= state_nxt;
            left_r  <= left_nxt;
        end
    end

    // Outputs follow the next state so they line up with the state register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_enable    <= 1'b0;
            fault_latched <= 1'b0;
            retries_left  <= 3'h0;
            warn_action   <= ACT_RESET;
        end else begin
            out_enable    <= run_cmd && (state_nxt == ST_RUN || state_nxt == ST_DELAY
                                         || state_nxt == ST_TRY);
            fault_latched <= state_nxt == ST_LATCH;
            retries_left  <= left_nxt;
            warn_action   <= (cmd_valid && cmd_write && acc_ok && dec.src == SRC_ACT)
                             ? cmd_wdata : action_r;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence rev_read_s;
        cmd_valid && !cmd_write && cmd_code == CMD_PROTO_REV && cmd_idx == 5'h00;
    endsequence

    sequence user_write_s;
        cmd_valid && cmd_write && cmd_code == CMD_USER_AREA && cmd_idx < LEN_USER_AREA;
    endsequence

    sequence user_read_s;
        cmd_valid && !cmd_write && cmd_code == CMD_USER_AREA && cmd_idx == $past(cmd_idx);
    endsequence

    sequence warn_in_run_s;
        state_r == ST_RUN && run_cmd && warn_in;
    endsequence

    sequence try_fail_s;
        state_r == ST_TRY && run_cmd && tmr_done && warn_in;
    endsequence

    rev_upper_a: assert property (rev_read_s |=> rsp_data[7:4] == 4'h3)
        else $error("Revision upper nibble wrong.");
    rev_lower_a: assert property (rev_read_s |=> rsp_data[3:0] == 4'h2)
        else $error("Revision lower nibble wrong.");
    date_ro_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_DATE
        |=> rsp_valid && rsp_nack)
        else $error("Write to date string was not refused.");
    user_back_a: assert property (user_write_s ##1 user_read_s
        |=> rsp_data == $past(cmd_wdata, 2) && !rsp_nack)
        else $error("User area did not read back.");
    ignore_run_a: assert property (warn_in_run_s and resp == RESP_IGNORE
        |=> out_enable && !fault_latched)
        else $error("Ignore response disturbed the output.");
    disable_now_a: assert property (warn_in_run_s and resp == RESP_DISABLE
        |=> !out_enable)
        else $error("Disable response left output on.");
    no_retry_a: assert property (warn_in_run_s and resp == RESP_DISABLE && retry == 3'h0
        |=> fault_latched ##1 (!out_enable || $past(fault_clear)))
        else $error("Zero retries did not latch off.");
    latch_hold_a: assert property (fault_latched && run_cmd && !fault_clear
        |=> fault_latched && !out_enable)
        else $error("Latched fault released without a clear.");
    latch_enter_a: assert property (warn_in_run_s and resp == RESP_LATCH
        |=> fault_latched [*1] ##0 !out_enable)
        else $error("Latch response did not disable.");
    retry_dec_a: assert property (state_r == ST_TRY && run_cmd && tmr_done && warn_in
        && left_r > 3'h1 && left_r != RETRY_FOREVER |=> left_r == $past(left_r) - 3'h1)
        else $error("Failed attempt did not use a retry.");
    delay_keep_a: assert property (warn_in_run_s and resp == RESP_DELAYED
        |=> state_r == ST_DELAY && out_enable)
        else $error("Delayed response did not keep running.");
    serial_ro_a: assert property (cmd_valid && cmd_write && cmd_code == CMD_SERIAL
        |=> rsp_valid && rsp_nack)
        else $error("Write to serial string was not refused.");
    try_start_a: assert property (state_r == ST_OFFW && run_cmd && tmr_done
        |=> state_r == ST_TRY && out_enable)
        else $error("Restart attempt did not begin after the interval.");
    last_try_a: assert property (try_fail_s and left_r == 3'h1
        |=> fault_latched && !out_enable && retries_left == 3'h0)
        else $error("Last failed attempt did not latch off.");
    forever_keep_a: assert property (try_fail_s and left_r == RETRY_FOREVER
        |=> state_r == ST_OFFW && retries_left == RETRY_FOREVER && !fault_latched)
        else $error("Unlimited retry stopped or counted down.");

endmodule // pmbid_bank

// *** verif/pmbid_host_model.sv ***
// Purpose: Host side of the command port, one byte access per clock.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes:   A burst ends with idle, so cmd_valid is never set twice in one time step.
`timescale 1ns/10ps
module pmbid_host_model (
    input  wire logic       clk,
    output logic            cmd_valid,
    output logic            cmd_write,
    output logic      [7:0] cmd_code,
    output logic      [4:0] cmd_idx,
    output logic      [7:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_idx   = 5'h00;
        cmd_wdata = 8'h00;
    end

    task automatic access(input logic wr, input logic [7:0] code, input logic [4:0] idx,
                          input logic [7:0] wd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_idx   = idx;
        cmd_wdata = wd;
        @(posedge clk);
    endtask

    // Released data is inverted so a stale byte never looks valid.
    task automatic idle();
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule // pmbid_host_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the identification bank and warning response.
// Assumes: Default string parameters of the bank.
// Notes:   Delay unit ticks are spaced wide so each interval is easy to observe.
`timescale 1ns/10ps
module tb import pmbid_pkg::*;;
    typedef struct packed {
        logic [7:0] d;
        logic [4:0] l;
        logic       n;
    } pmbid_exp_s;
    logic        clk, sys_rst, warn_in, unit_tick, fault_clear, run_cmd;
    logic        cmd_valid, cmd_write, rsp_valid, rsp_nack, out_enable, fault_latched;
    logic  [7:0] cmd_code, cmd_wdata, rsp_data, warn_action, b;
    logic  [4:0] cmd_idx, rsp_len;
    logic  [2:0] retries_left;
    logic  [7:0] ub [16];
    logic  [7:0] wcode [5] = '{CMD_MAKER_ID, CMD_MODEL, CMD_PROD_REV, CMD_LOCATION,
                               CMD_USER_AREA};
    logic  [4:0] wlen [5] = '{LEN_SHORT_STR, LEN_LONG_STR, LEN_SHORT_STR, LEN_SHORT_STR,
                              LEN_USER_AREA};
    pmbid_exp_s  exp_q [$];
    pmbid_exp_s  e;
    int          err_total = 0;
    int          samples_checked = 0;

    pmbid_bank u_pmbid_bank (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len), .rsp_nack(rsp_nack),
        .warn_in(warn_in), .unit_tick(unit_tick), .fault_clear(fault_clear),
        .run_cmd(run_cmd), .out_enable(out_enable), .fault_latched(fault_latched),
        .retries_left(retries_left), .warn_action(warn_action));
    pmbid_host_model u_pmbid_host_model (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_idx(cmd_idx), .cmd_wdata(cmd_wdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic wr, input logic [7:0] code, input logic [4:0] idx,
                       input logic [7:0] wd, input logic [7:0] ed, input logic [4:0] el,
                       input logic en);
        exp_q.push_back('{d: ed, l: el, n: en});
        u_pmbid_host_model.access(wr, code, idx, wd);
    endtask

    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rsp_valid", 8'(rsp_valid), 8'h00);
            end else begin
                e = exp_q.pop_front();
                check("rsp_data", rsp_data, e.d);
                check("rsp_len", 8'(rsp_len), 8'(e.l));
                check("rsp_nack", 8'(rsp_nack), 8'(e.n));
            end
        end
    end

    task automatic set_act(input logic [7:0] a);
        cmd(1'b1, CMD_WARN_ACT, 5'h00, a, 8'h00, LEN_ONE_BYTE, 1'b0);
        cmd(1'b0, CMD_WARN_ACT, 5'h00, 8'h00, a, LEN_ONE_BYTE, 1'b0);
        u_pmbid_host_model.idle();
        check("warn_action", warn_action, a);
    endtask

    task automatic tick();
        @(negedge clk) unit_tick = 1'b1;
        @(negedge clk) unit_tick = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic warn_on();
        @(negedge clk) warn_in = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    task automatic chk_out(input logic oe, input logic lat);
        check("out_enable", 8'(out_enable), 8'(oe));
        check("fault_latched", 8'(fault_latched), 8'(lat));
    endtask

    // Off-then-on of the run command clears any latch and aborts any sequence.
    task automatic restart();
        @(negedge clk) warn_in = 1'b0;
        run_cmd = 1'b0;
        repeat (2) @(negedge clk);
        chk_out(1'b0, 1'b0);
        run_cmd = 1'b1;
        repeat (2) @(negedge clk);
        chk_out(1'b1, 1'b0);
    endtask

    task automatic clear_fault();
        @(negedge clk) warn_in = 1'b0;
        fault_clear = 1'b1;
        @(negedge clk) fault_clear = 1'b0;
        repeat (2) @(negedge clk);
        chk_out(1'b1, 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h5ff1));
        sys_rst = 1'b1;
        warn_in = 1'b0;
        unit_tick = 1'b0;
        fault_clear = 1'b0;
        run_cmd = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        cmd(1'b0, CMD_PROTO_REV, 5'h00, 8'h00, 8'h32, LEN_ONE_BYTE, 1'b0);
        cmd(1'b0, CMD_WARN_ACT, 5'h00, 8'h00, ACT_RESET, LEN_ONE_BYTE, 1'b0);
        for (int i = 0; i < 5; i++) begin
            cmd(1'b0, wcode[i], wlen[i] - 5'h01, 8'h00, 8'h00, wlen[i], 1'b0);
            b = 8'($urandom);
            cmd(1'b1, wcode[i], 5'h00, b, 8'h00, wlen[i], 1'b0);
            cmd(1'b0, wcode[i], 5'h00, 8'h00, b, wlen[i], 1'b0);
            b = 8'($urandom);
            cmd(1'b1, wcode[i], wlen[i] - 5'h01, b, 8'h00, wlen[i], 1'b0);
            cmd(1'b0, wcode[i], wlen[i] - 5'h01, 8'h00, b, wlen[i], 1'b0);
            cmd(1'b0, wcode[i], wlen[i], 8'h00, 8'h00, wlen[i], 1'b1);
        end
        for (int j = 0; j < 16; j++) begin
            ub[j] = 8'($urandom);
            cmd(1'b1, CMD_USER_AREA, 5'(j), ub[j], 8'h00, LEN_USER_AREA, 1'b0);
        end
        for (int j = 0; j < 16; j++) begin
            cmd(1'b0, CMD_USER_AREA, 5'(j), 8'h00, ub[j], LEN_USER_AREA, 1'b0);
        end
        for (int j = 0; j < 12; j++) begin
            cmd(1'b0, CMD_DATE, 5'(j), 8'h00, 8'h30, LEN_SHORT_STR, 1'b0);
        end
        for (int j = 0; j < 20; j++) begin
            b = (j < 13) ? 8'h41 : 8'h20;
            cmd(1'b0, CMD_SERIAL, 5'(j), 8'h00, b, LEN_LONG_STR, 1'b0);
        end
        cmd(1'b1, CMD_DATE, 5'h00, 8'h55, 8'h00, LEN_SHORT_STR, 1'b1);
        cmd(1'b1, CMD_SERIAL, 5'h00, 8'h55, 8'h00, LEN_LONG_STR, 1'b1);
        cmd(1'b1, CMD_PROTO_REV, 5'h00, 8'h55, 8'h00, LEN_ONE_BYTE, 1'b1);
        cmd(1'b0, CMD_PROTO_REV, 5'h00, 8'h00, 8'h32, LEN_ONE_BYTE, 1'b0);
        cmd(1'b1, CMD_CTRL_ID, 5'h00, 8'h55, 8'h00, LEN_CTRL_STR, 1'b1);
        cmd(1'b0, CMD_CTRL_ID, 5'h07, 8'h00, 8'h58, LEN_CTRL_STR, 1'b0);
        cmd(1'b0, CMD_CTRL_REV, 5'h00, 8'h00, 8'h30, LEN_CTRL_STR, 1'b0);
        cmd(1'b0, 8'h9f, 5'h00, 8'h00, 8'h00, 5'h00, 1'b1);
        u_pmbid_host_model.idle();
        repeat (3) @(negedge clk);
        check("queue_left", 8'(exp_q.size()), 8'h00);
        set_act({RESP_IGNORE, 3'($urandom), 3'($urandom)});
        warn_on();
        repeat (3) tick();
        chk_out(1'b1, 1'b0);
        @(negedge clk) warn_in = 1'b0;
        for (int r = 1; r <= 6; r++) begin
            set_act({RESP_DISABLE, 3'(r), 3'h0});
            warn_on();
            chk_out(1'b0, 1'b0);
            check("retries_left", 8'(retries_left), 8'(r));
            for (int k = 1; k <= r; k++) begin
                tick();
                chk_out(1'b1, 1'b0);
                tick();
                chk_out(1'b0, k == r);
                check("retries_left", 8'(retries_left), 8'(r - k));
            end
            tick();
            chk_out(1'b0, 1'b1);
            clear_fault();
        end
        set_act({RESP_DISABLE, RETRY_NONE, 3'h0});
        warn_on();
        chk_out(1'b0, 1'b1);
        tick();
        chk_out(1'b0, 1'b1);
        clear_fault();
        set_act({RESP_LATCH, 3'h2, 3'h0});
        warn_on();
        chk_out(1'b0, 1'b1);
        @(negedge clk) warn_in = 1'b0;
        tick();
        chk_out(1'b0, 1'b1);
        restart();
        set_act({RESP_DISABLE, RETRY_FOREVER, 3'h0});
        warn_on();
        repeat (8) begin
            tick();
            tick();
            check("retries_left", 8'(retries_left), 8'h07);
            check("fault_latched", 8'(fault_latched), 8'h00);
        end
        restart();
        set_act({RESP_DELAYED, 3'h1, 3'h2});
        warn_on();
        repeat (3) begin
            tick();
            chk_out(1'b1, 1'b0);
        end
        tick();
        chk_out(1'b0, 1'b0);
        restart();
        set_act({RESP_DELAYED, 3'h1, 3'h1});
        warn_on();
        @(negedge clk) warn_in = 1'b0;
        repeat (3) tick();
        chk_out(1'b1, 1'b0);
        finish_test();
    end
endmodule // tb
